// ==== design/aamc_pkg.sv ====
// Shared constants, commands and carriers for the auxiliary measurement control block
package aamc_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // System clock and conversion clock rates
    localparam int unsigned CLOCK_KHZ = 200000;        // System clock, 200 MHz
    localparam int unsigned FCLK_NORMAL_KHZ = 1024;    // Conversion clock, normal operation
    localparam int unsigned FCLK_TURBO_KHZ = 2048;     // Conversion clock, turbo operation
    localparam int unsigned ACC_W = 18;                // Holds CLOCK_KHZ plus one step

    // Half-period accumulator steps: half ticks arrive at twice the conversion clock rate
    localparam logic [ACC_W-1:0] HALF_STEP_NORMAL = ACC_W'(2 * FCLK_NORMAL_KHZ);
    localparam logic [ACC_W-1:0] HALF_STEP_TURBO = ACC_W'(2 * FCLK_TURBO_KHZ);
    localparam logic [ACC_W-1:0] ACC_WRAP = ACC_W'(CLOCK_KHZ);

    ////////////////////////////////////////////////////////////////////////////////
    // First-conversion delay, in tenths of a conversion clock period as printed
    localparam int unsigned START_DELAY_NORMAL_X10 = 285;   // 28.5 periods
    localparam int unsigned START_DELAY_TURBO_X10 = 1050;   // 105 periods
    localparam int unsigned DLY_W = 8;
    // Same delays counted in half periods, so the half period is exact
    localparam logic [DLY_W-1:0] START_HALVES_NORMAL = DLY_W'(START_DELAY_NORMAL_X10 * 2 / 10);
    localparam logic [DLY_W-1:0] START_HALVES_TURBO = DLY_W'(START_DELAY_TURBO_X10 * 2 / 10);

    ////////////////////////////////////////////////////////////////////////////////
    // Command latch: the eighth falling serial clock edge of the command byte
    localparam int unsigned EDGE_W = 4;
    localparam logic [EDGE_W-1:0] EDGE_LAST = 4'h7;    // Index of the eighth edge
    localparam logic [EDGE_W-1:0] EDGE_DONE = 4'h8;    // Byte fully counted

    ////////////////////////////////////////////////////////////////////////////////
    // Field codes
    localparam logic [2:0] LEVEL_OFF = 3'h0;           // Excitation disabled
    localparam logic [2:0] ROUTE_NONE = 3'h0;          // Source not routed
    localparam logic [3:0] SEL_DEFAULT = 4'h0;         // Selection while in temperature mode
    localparam logic [3:0] SEL_REF_MONITOR = 4'hc;     // External reference divided by four
    localparam logic [3:0] SEL_SUPPLY_MONITOR = 4'hd;  // Analog supply divided by four
    localparam logic [3:0] SEL_MID_SHORT = 4'he;       // Both inputs shorted to mid-supply
    localparam logic [2:0] GAIN_UNITY = 3'h0;          // Gain of one
    localparam logic [1:0] REF_INTERNAL = 2'h0;        // Internal reference
    localparam logic [1:0] TEMP_PAD = 2'h0;            // Unused low bits of a temperature word

    // Temperature code checkpoints, one count is 0.03125 degrees
    localparam logic [13:0] TEMP_CODE_PLUS25 = 14'h0320;
    localparam logic [13:0] TEMP_CODE_MINUS25 = 14'h3ce0;

    ////////////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [1:0] {
        AAMC_CMD_NONE = 2'h0,
        AAMC_CMD_START = 2'h1,
        AAMC_CMD_SLEEP = 2'h2
    } aamc_cmd_t;

    // Gray along idle, delay, convert
    typedef enum logic [1:0] {
        AAMC_ST_IDLE = 2'h0,
        AAMC_ST_DELAY = 2'h1,
        AAMC_ST_CONV = 2'h3
    } aamc_state_t;

    typedef struct packed {
        logic [2:0] excitation_level;
        logic [2:0] first_source_route;
        logic [2:0] second_source_route;
        logic fault_probe_enable;
        logic [3:0] input_select;
        logic thermometer_enable;
        logic [2:0] gain;
        logic pga_bypass;
        logic [1:0] ref_select;
        logic turbo;
        logic continuous;
    } aamc_cfg_t;

    typedef struct packed {
        logic bias_en;
        logic [2:0] level;
        logic [2:0] first_route;
        logic [2:0] second_route;
        logic probe_source_en;
        logic probe_sink_en;
        logic [3:0] mux_sel;
        logic short_inputs;
        logic [2:0] gain_eff;
        logic pga_bypass_eff;
        logic [1:0] ref_eff;
        logic temp_mode;
    } aamc_analog_t;

endpackage : aamc_pkg

// ==== design/aamc_clk_div.sv ====
// Fractional divider giving conversion clock half-period and full-period enables
`timescale 1ns/1ps
module aamc_clk_div
    import aamc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic turbo,
    output logic half_tick,
    output logic tick
);

    ////////////////////////////////////////////////////////////////////////////////
    logic [ACC_W-1:0] acc_q;   // Phase accumulator
    logic [ACC_W-1:0] acc_d;   // Accumulator plus step
    logic phase_q;             // Which half of the period we are in

    // Step picks the rate; the average is exact even though one period is not whole cycles
    assign acc_d = acc_q + (turbo ? HALF_STEP_TURBO : HALF_STEP_NORMAL);

    // Accumulator and half-tick pulse
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            acc_q <= '0;
            half_tick <= 1'b0;
        end else if (acc_d >= ACC_WRAP) begin
            acc_q <= acc_d - ACC_WRAP;
            half_tick <= 1'b1;
        end else begin
            acc_q <= acc_d;
            half_tick <= 1'b0;
        end
    end

    // Full period enable on every second half tick
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            phase_q <= 1'b0;
            tick <= 1'b0;
        end else if (acc_d >= ACC_WRAP) begin
            phase_q <= ~phase_q;
            tick <= phase_q;
        end else begin
            tick <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    AST_TICK_ON_HALF: assert property (@(posedge clk) disable iff (!rst_n)
        tick |-> half_tick)
        else $error("full tick without half tick");

endmodule : aamc_clk_div

// ==== design/aamc_ctrl.sv ====
// Auxiliary measurement control: start timing, excitation, probes, monitors, temperature
//
// Contract
// - First conversion waits 28.5 or 105 periods.
// - Period is 1/1.024 MHz or 1/2.048 MHz.
// - Three-bit level sets both matched source currents.
// - Each source routed independently, same pin allowed.
// - Single-shot keeps sources on when level nonzero.
// - Sleep command powers down both sources.
// - Bias on for nonzero level; current needs routing.
// - Probe bit sources positive, sinks negative input.
// - Monitor selection forces unity gain, bypass.
// - Code 1101 measures supply, internal reference.
// - Code 1100 measures reference, internal reference.
// - Thermometer bit ignores first register, internal reference.
// - Temperature result 14 bits left-justified.
// - One count equals 0.03125 degrees Celsius.
// - Temperature uses same start and read sequence.
// - Selection shorts both inputs to mid-supply.
// - Command latched on eighth falling serial edge.
`timescale 1ns/1ps
module aamc_ctrl
    import aamc_pkg::*;
(
    input wire logic CLOCK,
    input wire logic RST_N,
    input wire logic SCL_PIN,
    input wire logic CMD_BYTE_START,
    input wire aamc_cmd_t CMD_KIND,
    input wire aamc_cfg_t CFG,
    input wire logic [15:0] CONV_PERIODS,
    input wire logic [15:0] RAW_RESULT,
    input wire logic [13:0] TEMP_CODE,
    input wire logic RESULT_READ,
    output aamc_analog_t ANALOG,
    output logic [15:0] RESULT,
    output logic RESULT_READY_N,
    output logic CONVERTING,
    output logic POWERED_DOWN
);

    ////////////////////////////////////////////////////////////////////////////////
    // Conversion clock enables
    logic half_tick;   // Twice the conversion clock rate
    logic tick;        // One conversion clock period
    logic div_rst_n;   // Divider reset, also pulsed to restart the period grid

    // Restarted like an oscillator that wakes on demand, so no stale phase shortens a wait
    aamc_clk_div u_div (
        .clk(CLOCK),
        .rst_n(div_rst_n),
        .turbo(CFG.turbo),
        .half_tick(half_tick),
        .tick(tick)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Serial clock pin synchroniser and falling edge detect
    logic scl_meta_q;              // First stage, read only by the second
    logic scl_sync_q;              // Second stage
    logic scl_prev_q;              // Delayed copy for edge detection
    logic scl_fall;                // One cycle per falling edge
    logic [EDGE_W-1:0] edge_cnt_q; // Falling edges seen in the command byte
    logic cmd_latch;               // Command latched this cycle
    logic start_go;                // Start command latched
    logic sleep_go;                // Sleep command latched

    // Two flops before anything looks at the pin
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            scl_meta_q <= 1'b1;
            scl_sync_q <= 1'b1;
            scl_prev_q <= 1'b1;
        end else begin
            scl_meta_q <= SCL_PIN;
            scl_sync_q <= scl_meta_q;
            scl_prev_q <= scl_sync_q;
        end
    end

    assign scl_fall = scl_prev_q & ~scl_sync_q;

    // Edge counter restarts with each command byte and stops after eight edges
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            edge_cnt_q <= EDGE_DONE;
        end else if (CMD_BYTE_START) begin
            edge_cnt_q <= '0;
        end else if (scl_fall && edge_cnt_q != EDGE_DONE) begin
            edge_cnt_q <= edge_cnt_q + 4'h1;
        end
    end

    // Latch moment is the eighth falling edge; all delays count from here
    assign cmd_latch = scl_fall && (edge_cnt_q == EDGE_LAST) && !CMD_BYTE_START;
    assign start_go = cmd_latch && (CMD_KIND == AAMC_CMD_START);
    assign sleep_go = cmd_latch && (CMD_KIND == AAMC_CMD_SLEEP);

    ////////////////////////////////////////////////////////////////////////////////
    // Conversion sequencer
    aamc_state_t state_q;          // Sequencer state
    logic [DLY_W-1:0] dly_cnt_q;   // Half periods spent in the start delay
    logic [15:0] conv_cnt_q;       // Periods spent in the current conversion
    logic [DLY_W-1:0] dly_target;  // Half periods to wait for the chosen speed
    logic delay_end;               // Start delay finishes this cycle
    logic conv_end;                // Conversion finishes this cycle
    logic sleep_pending_q;         // Sleep waits for the running conversion

    // Turbo needs more periods, but each is half as long
    assign dly_target = CFG.turbo ? START_HALVES_TURBO : START_HALVES_NORMAL;
    assign delay_end = (state_q == AAMC_ST_DELAY) && half_tick
        && (dly_cnt_q == dly_target - 8'h01);
    assign conv_end = (state_q == AAMC_ST_CONV) && tick
        && (conv_cnt_q == CONV_PERIODS - 16'h0001);

    // Fresh grid at the latch and again at the end of the delay keeps both lengths exact
    assign div_rst_n = RST_N && !start_go && !delay_end;

    // A new start always restarts the delay, even mid-conversion
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            state_q <= AAMC_ST_IDLE;
        end else if (start_go) begin
            state_q <= AAMC_ST_DELAY;
        end else begin
            case (state_q)
                AAMC_ST_DELAY: begin
                    if (delay_end) begin
                        state_q <= AAMC_ST_CONV;
                    end
                end
                AAMC_ST_CONV: begin
                    // Continuous runs back to back unless sleep is waiting
                    if (conv_end && (!CFG.continuous || sleep_pending_q || sleep_go)) begin
                        state_q <= AAMC_ST_IDLE;
                    end
                end
                default: begin
                    state_q <= AAMC_ST_IDLE;
                end
            endcase
        end
    end

    // Start delay counter in half periods
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            dly_cnt_q <= '0;
        end else if (start_go) begin
            dly_cnt_q <= '0;
        end else if (state_q == AAMC_ST_DELAY && half_tick) begin
            dly_cnt_q <= dly_cnt_q + 8'h01;
        end
    end

    // Conversion length counter in whole periods
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            conv_cnt_q <= '0;
        end else if (start_go || delay_end || conv_end) begin
            conv_cnt_q <= '0;
        end else if (state_q == AAMC_ST_CONV && tick) begin
            conv_cnt_q <= conv_cnt_q + 16'h0001;
        end
    end

    // Sleep during a conversion lets it finish first
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            sleep_pending_q <= 1'b0;
        end else if (start_go || conv_end) begin
            sleep_pending_q <= 1'b0;
        end else if (sleep_go && state_q != AAMC_ST_IDLE) begin
            sleep_pending_q <= 1'b1;
        end
    end

    // Core power state seen by the host
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            POWERED_DOWN <= 1'b1;
        end else if (start_go) begin
            POWERED_DOWN <= 1'b0;
        end else if ((sleep_go && state_q == AAMC_ST_IDLE)
                || (conv_end && (sleep_pending_q || sleep_go))) begin
            POWERED_DOWN <= 1'b1;
        end
    end

    // Busy flag registered for the output
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            CONVERTING <= 1'b0;
        end else begin
            CONVERTING <= (state_q != AAMC_ST_IDLE);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Result word and ready strobe
    // Same start and read path for both kinds; only the word source differs
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            RESULT <= '0;
        end else if (conv_end) begin
            if (CFG.thermometer_enable) begin
                // Low two bits carry no temperature, code scale passes through as is
                RESULT <= {TEMP_CODE, TEMP_PAD};
            end else begin
                RESULT <= RAW_RESULT;
            end
        end
    end

    // Ready low on completion; completion wins over a read in the same cycle
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            RESULT_READY_N <= 1'b1;
        end else if (conv_end) begin
            RESULT_READY_N <= 1'b0;
        end else if (RESULT_READ) begin
            RESULT_READY_N <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Excitation power: only the sleep command turns the sources off
    logic excite_off_q;   // Sources powered down by sleep
    logic bias_on;        // Bias circuit runs

    // Stays on between single-shot conversions; restart brings it back
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            excite_off_q <= 1'b0;
        end else if (sleep_go) begin
            excite_off_q <= 1'b1;
        end else if (start_go) begin
            excite_off_q <= 1'b0;
        end
    end

    // Bias depends on level and the sleep state; routing does not matter
    assign bias_on = (CFG.excitation_level != LEVEL_OFF) && !excite_off_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Input path decode
    logic temp_mode;   // Temperature mode overrides the first register
    logic monitor;     // A supply or reference monitor is selected

    assign temp_mode = CFG.thermometer_enable;
    assign monitor = !temp_mode && (CFG.input_select == SEL_SUPPLY_MONITOR
        || CFG.input_select == SEL_REF_MONITOR);

    // Analog controls, registered so every output leaves a flop
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            ANALOG <= '0;
        end else begin
            // Both sources share one level, the pair stays matched
            ANALOG.bias_en <= bias_on;
            ANALOG.level <= bias_on ? CFG.excitation_level : LEVEL_OFF;
            // Routes are independent; both may name the same pin
            ANALOG.first_route <= bias_on ? CFG.first_source_route : ROUTE_NONE;
            ANALOG.second_route <= bias_on ? CFG.second_source_route : ROUTE_NONE;
            // Probes follow whatever inputs the multiplexer has chosen
            ANALOG.probe_source_en <= CFG.fault_probe_enable;
            ANALOG.probe_sink_en <= CFG.fault_probe_enable;
            ANALOG.mux_sel <= temp_mode ? SEL_DEFAULT : CFG.input_select;
            ANALOG.short_inputs <= !temp_mode && CFG.input_select == SEL_MID_SHORT;
            // Monitors are coarse, so gain is forced to one whatever was set
            if (monitor || temp_mode) begin
                ANALOG.gain_eff <= GAIN_UNITY;
            end else begin
                ANALOG.gain_eff <= CFG.gain;
            end
            ANALOG.pga_bypass_eff <= monitor || (!temp_mode && CFG.pga_bypass);
            if (monitor || temp_mode) begin
                ANALOG.ref_eff <= REF_INTERNAL;
            end else begin
                ANALOG.ref_eff <= CFG.ref_select;
            end
            ANALOG.temp_mode <= temp_mode;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    AST_DELAY_LEN: assert property (@(posedge CLOCK) disable iff (!RST_N)
        $rose(state_q == AAMC_ST_CONV)
            |-> $past(half_tick) && $past(dly_cnt_q) == dly_target - 8'h01)
        else $error("first conversion began after wrong delay");

    AST_LATCH_START: assert property (@(posedge CLOCK) disable iff (!RST_N)
        start_go |=> state_q == AAMC_ST_DELAY && dly_cnt_q == '0)
        else $error("start not taken at eighth falling edge");

    AST_SLEEP_OFF: assert property (@(posedge CLOCK) disable iff (!RST_N)
        sleep_go |-> ##2 (!ANALOG.bias_en && ANALOG.first_route == ROUTE_NONE
            && ANALOG.second_route == ROUTE_NONE))
        else $error("sources still on after sleep");

    AST_BIAS_LEVEL: assert property (@(posedge CLOCK) disable iff (!RST_N)
        ##1 ANALOG.bias_en == ($past(CFG.excitation_level) != LEVEL_OFF && !$past(excite_off_q)))
        else $error("bias does not follow level");

    AST_MON_GAIN: assert property (@(posedge CLOCK) disable iff (!RST_N)
        monitor |=> ANALOG.gain_eff == GAIN_UNITY && ANALOG.pga_bypass_eff)
        else $error("monitor selection kept gain stage");

    AST_SUPPLY_REF: assert property (@(posedge CLOCK) disable iff (!RST_N)
        (!temp_mode && CFG.input_select == SEL_SUPPLY_MONITOR)
            |=> ANALOG.ref_eff == REF_INTERNAL && ANALOG.mux_sel == SEL_SUPPLY_MONITOR)
        else $error("supply monitor not on internal reference");

    AST_TEMP_REF: assert property (@(posedge CLOCK) disable iff (!RST_N)
        temp_mode |=> ANALOG.ref_eff == REF_INTERNAL && ANALOG.mux_sel == SEL_DEFAULT
            && ANALOG.temp_mode)
        else $error("temperature mode did not override settings");

    AST_TEMP_WORD: assert property (@(posedge CLOCK) disable iff (!RST_N)
        (conv_end && CFG.thermometer_enable)
            |=> RESULT[15:2] == $past(TEMP_CODE) && RESULT[1:0] == TEMP_PAD)
        else $error("temperature word not left-justified");

    AST_TEMP_SCALE: assert property (@(posedge CLOCK) disable iff (!RST_N)
        (conv_end && CFG.thermometer_enable && TEMP_CODE == TEMP_CODE_MINUS25)
            |=> RESULT == {TEMP_CODE_MINUS25, TEMP_PAD})
        else $error("temperature code altered");

    AST_READY_LOW: assert property (@(posedge CLOCK) disable iff (!RST_N)
        conv_end |=> !RESULT_READY_N ##1 (!RESULT_READY_N || $past(RESULT_READ)))
        else $error("ready not driven low on completion");

    AST_SHORT_SEL: assert property (@(posedge CLOCK) disable iff (!RST_N)
        (!temp_mode && CFG.input_select == SEL_MID_SHORT) |=> ANALOG.short_inputs)
        else $error("short selection not applied");

    AST_PROBE_PAIR: assert property (@(posedge CLOCK) disable iff (!RST_N)
        CFG.fault_probe_enable |=> ANALOG.probe_source_en && ANALOG.probe_sink_en)
        else $error("probe sources not both on");

endmodule : aamc_ctrl

// ==== dv/aamc_host_model.sv ====
// Host model: frames command bytes on the serial clock pin
`timescale 1ns/1ps
module aamc_host_model
    import aamc_pkg::*;
(
    input wire logic clk,
    output logic scl,
    output logic byte_start,
    output aamc_cmd_t kind
);
    // Pull-up keeps the clock high between frames
    initial begin
        scl = 1'b1;
        byte_start = 1'b0;
        kind = AAMC_CMD_NONE;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // One byte; slow edges so the pin synchroniser never misses a fall
    task automatic send(input aamc_cmd_t k);
        @(negedge clk);
        byte_start = 1'b1;
        kind = k;
        @(negedge clk);
        byte_start = 1'b0;
        repeat (8) begin
            repeat (4) @(negedge clk);
            scl = 1'b0;
            repeat (4) @(negedge clk);
            scl = 1'b1;
        end
        // Hold the command until the latch has surely sampled it
        repeat (6) @(negedge clk);
        kind = AAMC_CMD_NONE;
    endtask : send
endmodule : aamc_host_model

// ==== dv/test_adc_aux_measurement_control.sv ====
// Self-checking bench for the auxiliary measurement control block
`timescale 1ns/1ps
module test_adc_aux_measurement_control;
    import aamc_pkg::*;
    logic CLOCK, RST_N, SCL_PIN, CMD_BYTE_START, RESULT_READ;
    aamc_cmd_t CMD_KIND;
    aamc_cfg_t CFG;
    logic [15:0] CONV_PERIODS, RAW_RESULT, RESULT;
    logic [13:0] TEMP_CODE;
    aamc_analog_t ANALOG;
    logic RESULT_READY_N, CONVERTING, POWERED_DOWN;
    int num_errors = 0;
    int compares = 0;
    localparam int SRC_STARTUP_CYCLES = 40000; // 200 us of source startup at 5 ns
    aamc_host_model host (.clk(CLOCK), .scl(SCL_PIN), .byte_start(CMD_BYTE_START),
        .kind(CMD_KIND));
    aamc_ctrl dut (.CLOCK(CLOCK), .RST_N(RST_N), .SCL_PIN(SCL_PIN),
        .CMD_BYTE_START(CMD_BYTE_START), .CMD_KIND(CMD_KIND), .CFG(CFG),
        .CONV_PERIODS(CONV_PERIODS), .RAW_RESULT(RAW_RESULT), .TEMP_CODE(TEMP_CODE),
        .RESULT_READ(RESULT_READ), .ANALOG(ANALOG), .RESULT(RESULT),
        .RESULT_READY_N(RESULT_READY_N), .CONVERTING(CONVERTING),
        .POWERED_DOWN(POWERED_DOWN));
    ////////////////////////////////////////////////////////////////////////////////
    // Compare tasks: values, and durations within a tolerance
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string w);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t %s got %h exp %h", $time, w, got, exp);
        end
    endtask : chk
    task automatic chk_near(input int got, input int exp, input int tol, input string w);
        compares++;
        if (got < exp - tol || got > exp + tol) begin
            num_errors++;
            $display("ERROR %0t %s took %0d exp %0d", $time, w, got, exp);
        end
    endtask : chk_near
    // Controls answer within two edges; three leaves margin
    task automatic settle();
        repeat (3) @(negedge CLOCK);
    endtask : settle
    ////////////////////////////////////////////////////////////////////////////////
    // Level first, then both sources onto one pin
    task automatic t_excite();
        CFG.excitation_level = 3'h5;
        settle();
        chk({ANALOG.bias_en, ANALOG.first_route}, 4'h8, "bias");
        repeat (SRC_STARTUP_CYCLES) @(negedge CLOCK);
        CFG.first_source_route = 3'h2;
        CFG.second_source_route = 3'h2;
        settle();
        chk({ANALOG.level, ANALOG.first_route, ANALOG.second_route}, 9'h152, "rt");
        $display("t_excite done");
    endtask : t_excite
    // Monitors force unity gain and internal reference despite other settings
    task automatic t_mux();
        CFG.gain = 3'h4;
        CFG.ref_select = 2'h2;
        for (int c = 12; c < 14; c++) begin
            CFG.input_select = 4'(c);
            settle();
            chk({ANALOG.gain_eff, ANALOG.pga_bypass_eff, ANALOG.ref_eff}, 6'h4, "mon");
        end
        CFG.input_select = SEL_MID_SHORT;
        CFG.fault_probe_enable = 1'b1;
        settle();
        chk({ANALOG.short_inputs, ANALOG.probe_source_en, ANALOG.probe_sink_en}, 3'h7, "sp");
        CFG.thermometer_enable = 1'b1;
        settle();
        chk({ANALOG.temp_mode, ANALOG.mux_sel, ANALOG.ref_eff}, 7'h40, "temp");
        $display("t_mux done");
    endtask : t_mux
    // Start, time the first result, read it back; continuous runs also time the next one
    task automatic t_conv(input logic tb, input logic ts, input logic cm, input int halves,
            input int khz, input logic [13:0] tc);
        int n;
        CFG.turbo = tb;
        CFG.thermometer_enable = ts;
        CFG.continuous = cm;
        TEMP_CODE = tc;
        host.send(AAMC_CMD_START);
        chk({CONVERTING, POWERED_DOWN}, 2'h2, "busy");
        // Counted from the eighth pin fall, ten cycles before send returns
        n = 10;
        while (RESULT_READY_N !== 1'b0 && n < 20000) begin
            @(negedge CLOCK);
            n++;
        end
        // Pin synchroniser, latch and divider restarts add five cycles
        chk_near(n, (halves + 2 * CONV_PERIODS) * CLOCK_KHZ / (2 * khz) + 5, 3, "dly");
        chk(RESULT, ts ? {tc, TEMP_PAD} : RAW_RESULT, "res");
        settle();
        chk({ANALOG.bias_en, RESULT_READY_N}, 2'h2, "idle");
        RESULT_READ = 1'b1;
        @(negedge CLOCK);
        RESULT_READ = 1'b0;
        @(negedge CLOCK);
        chk(RESULT_READY_N, 1'b1, "rdy");
        if (cm) begin
            // Five falling edges have passed since ready went low
            n = 5;
            while (RESULT_READY_N !== 1'b0 && n < 2000) begin
                @(negedge CLOCK);
                n++;
            end
            chk_near(n, 2 * CONV_PERIODS * CLOCK_KHZ / (2 * khz), 3, "next");
        end
        $display("t_conv done");
    endtask : t_conv
    ////////////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : finish_test
    initial begin
        CLOCK = 1'b0;
        forever #2.5 CLOCK = ~CLOCK;
    end
    // Longest run is near 64000 cycles, most of it the source startup wait
    initial begin
        repeat (80000) @(posedge CLOCK);
        num_errors++;
        $display("ERROR %0t watchdog", $time);
        finish_test();
    end
    initial begin
        RST_N = 1'b0;
        RESULT_READ = 1'b0;
        CFG = '0;
        CONV_PERIODS = 16'h0002;
        RAW_RESULT = 16'h1234;
        TEMP_CODE = '0;
        repeat (2) @(posedge CLOCK);
        @(negedge CLOCK);
        RST_N = 1'b1;
        chk({RESULT_READY_N, POWERED_DOWN, CONVERTING, ANALOG}, 27'h6000000, "rst");
        t_excite();
        t_mux();
        t_conv(1'b0, 1'b1, 1'b0, 57, FCLK_NORMAL_KHZ, 14'h3ce0);
        t_conv(1'b1, 1'b1, 1'b0, 210, FCLK_TURBO_KHZ, 14'h0320);
        t_conv(1'b0, 1'b0, 1'b1, 57, FCLK_NORMAL_KHZ, 14'h0000);
        // Sleep lands inside a continuous conversion, which must still finish
        host.send(AAMC_CMD_SLEEP);
        settle();
        chk(ANALOG.bias_en, 1'b0, "off");
        repeat (500) @(negedge CLOCK);
        chk({ANALOG.bias_en, POWERED_DOWN, CONVERTING}, 3'h2, "sleep");
        finish_test();
    end
endmodule : test_adc_aux_measurement_control
